//--- omr_chk_assertions.sv
// checker: port assertions for the operating mode register
`timescale 1ns/1ns
`default_nettype none
module omr_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_secure,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_int_access,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_ext_echo,
  input wire logic [2:0] o_mode_select_field,
  input wire logic o_internal_visibility,
  input wire logic o_int_visible_cycle,
  input wire logic o_port_k_mapped
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire [2:0] m = o_mode_select_field;
  wire hit = i_addr == omr_pkg::MODE_REG_ADDR;
  wire off = m[0] || m == 3'h6;
  sequence s_acc; (i_rd || i_wr) && hit; endsequence
  property p_rd; i_rd && hit && !off |=> o_rvalid && !o_ext_echo; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_echo; s_acc ##0 off |=> o_ext_echo && !o_rvalid; endproperty
  a_echo: assert property (p_echo) else $error("unmapped access not echoed");
  property p_lock; m[0] |=> $stable(m); endproperty
  a_lock: assert property (p_lock) else $error("locked mode changed");
  property p_nop6; m != 3'h6 && !$past(i_rst) |=> m != 3'h6; endproperty
  a_nop6: assert property (p_nop6) else $error("entered peripheral mode");
  property p_sec; i_secure && i_wr |=> $stable(m); endproperty
  a_sec: assert property (p_sec) else $error("mode changed while secure");
  property p_wr;
    i_wr && hit && m == 3'h0 && !i_secure && i_wdata[7:5] != 3'h6
      |=> m == $past(i_wdata[7:5]) && o_internal_visibility == $past(i_wdata[3]);
  endproperty
  a_wr: assert property (p_wr) else $error("special mode write lost");
  property p_vis; 1'b1 |=> o_int_visible_cycle == $past(i_int_access && o_internal_visibility); endproperty
  a_vis: assert property (p_vis) else $error("visible cycle wrong");
  property p_kmap; !$past(i_rst) && $past(m[1:0]) == 2'b00 |-> o_port_k_mapped; endproperty
  a_kmap: assert property (p_kmap) else $error("port k unmapped in single chip");
  property p_rsv; o_rvalid |-> !o_rdata[4] && !o_rdata[2] && o_rdata[7:5] == m; endproperty
  a_rsv: assert property (p_rsv) else $error("read data fields wrong");
endmodule : omr_chk
bind omr_operating_mode omr_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_secure(i_secure),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_int_access(i_int_access),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_ext_echo(o_ext_echo), .o_mode_select_field(o_mode_select_field),
  .o_internal_visibility(o_internal_visibility), .o_int_visible_cycle(o_int_visible_cycle),
  .o_port_k_mapped(o_port_k_mapped));
`default_nettype wire

//--- omr_operating_mode.sv
// module: operating mode control register with mode-dependent write permissions
// Notes on behaviour
// - bits 7:5 report the current operating mode with the eight documented encodings.
// - when the lowest mode bit is 1 all mode bit writes are ignored.
// - in special single-chip and special test modes the mode bits are writable but never to or from peripheral mode.
// - in normal single-chip mode the top bit is fixed and the lower two are writable once, only to normal expanded.
// - while secure, mode bit writes are rejected.
// - from special modes a write to normal single-chip leaves one write; to expanded or emulation leaves none.
// - written values take effect one cycle after the write cycle.
// - in expanded and peripheral modes the register is unmapped and accesses go to the external bus.
// - peripheral mode cannot reach the register; reset values follow the strapped mode.
// - the visibility bit makes internal accesses appear on the external bus.
// - visibility and port K emulation bits are write once in normal, never in emulation, anytime in special modes.
// - with port K emulation set in an expanded mode the port K registers leave the map.
// - port K registers are always mapped in single-chip modes and never in peripheral mode.
// - the port E emulation bit is writable only in special modes.
// - with port E emulation set in expanded or peripheral mode the port E registers leave the map.
// - reads are allowed whenever the register is in the map.
`timescale 1ns/1ns
`default_nettype none
module omr_operating_mode (
  input wire logic i_ref_clk, // 20 MHz system bus clock
  input wire logic i_rst, // async reset, active high
  input wire logic [2:0] i_mode_strap, // mode pins, sampled while reset is high
  input wire logic i_secure, // device runs in secure mode
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic i_int_access, // an internal bus access is in progress
  output logic [7:0] o_rdata, // read data, one cycle after i_rd
  output logic o_rvalid, // read answered on chip
  output logic o_ext_echo, // access passed to external bus
  output logic [2:0] o_mode_select_field, // current operating mode
  output logic o_internal_visibility, // visibility bit
  output logic o_int_visible_cycle, // internal access shown externally
  output logic o_port_k_mapped, // port k data and direction regs in map
  output logic o_port_e_mapped // port e data and direction regs in map
);
  // strap sync: three flops, accepted when the last two agree
  logic [2:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_s1_d, strap_s2_d, strap_s3_d;
  logic [2:0] strap_ok_q, strap_ok_d;
  logic in_reset_q, in_reset_d;

  logic [2:0] mode_q, mode_d;
  logic internal_visibility_q, internal_visibility_d;
  logic emk_q, emk_d;
  logic eme_q, eme_d;
  logic mode_once_q, mode_once_d; // one mode write still allowed
  logic internal_visibility_once_q, internal_visibility_once_d;
  logic emk_once_q, emk_once_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic echo_q, echo_d;
  logic vis_cyc_q, vis_cyc_d;
  logic pk_map_q, pk_map_d;
  logic pe_map_q, pe_map_d;

  logic is_special, is_emul, is_normal, is_single, is_periph, is_expanded;
  logic mapped, hit, wr_hit;
  logic [2:0] wmode;

  always_comb begin
    strap_s1_d = i_mode_strap;
    strap_s2_d = strap_s1_q;
    strap_s3_d = strap_s2_q;
    strap_ok_d = (strap_s2_q == strap_s3_q) ? strap_s3_q : strap_ok_q;
    in_reset_d = 1'b0;
  end

  // strap chain runs through reset so the pins are sampled while reset is high
  always_ff @(posedge i_ref_clk) begin
    strap_s1_q <= strap_s1_d;
    strap_s2_q <= strap_s2_d;
    strap_s3_q <= strap_s3_d;
    strap_ok_q <= strap_ok_d;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= in_reset_d;
    end
  end

  always_comb begin
    is_emul = (mode_q == omr_pkg::OMR_EMUL_NARROW) || (mode_q == omr_pkg::OMR_EMUL_WIDE);
    is_special = (mode_q == omr_pkg::OMR_SPECIAL_SINGLE) || (mode_q == omr_pkg::OMR_SPECIAL_TEST)
      || (mode_q == omr_pkg::OMR_SPECIAL_PERIPH);
    is_normal = !is_emul && !is_special;
    is_single = (mode_q == omr_pkg::OMR_SPECIAL_SINGLE) || (mode_q == omr_pkg::OMR_NORMAL_SINGLE);
    is_periph = (mode_q == omr_pkg::OMR_SPECIAL_PERIPH);
    is_expanded = mode_q[0];
    mapped = !is_expanded && !is_periph;
    hit = (i_addr == omr_pkg::MODE_REG_ADDR);
    wr_hit = i_wr && hit && mapped;
    wmode = i_wdata[omr_pkg::MODE_LSB +: 3];
  end

  // next state of the register
  always_comb begin
    mode_d = mode_q;
    internal_visibility_d = internal_visibility_q;
    emk_d = emk_q;
    eme_d = eme_q;
    mode_once_d = mode_once_q;
    internal_visibility_once_d = internal_visibility_once_q;
    emk_once_d = emk_once_q;
    if (in_reset_q) begin
      // load the mode-dependent reset configuration once straps settle
      mode_d = strap_ok_q;
      mode_once_d = 1'b1;
      internal_visibility_once_d = 1'b1;
      emk_once_d = 1'b1;
      case (strap_ok_q)
        omr_pkg::OMR_EMUL_NARROW, omr_pkg::OMR_EMUL_WIDE: begin
          {internal_visibility_d, emk_d, eme_d} = omr_pkg::RST_FLAGS_EMUL;
        end
        omr_pkg::OMR_SPECIAL_TEST: begin
          {internal_visibility_d, emk_d, eme_d} = omr_pkg::RST_FLAGS_TEST;
        end
        default: begin
          {internal_visibility_d, emk_d, eme_d} = omr_pkg::RST_FLAGS_OTHER;
        end
      endcase
    end else if (wr_hit) begin
      if (!i_secure && !mode_q[0] && mode_once_q) begin
        if (!mode_q[2]) begin
          if (wmode != omr_pkg::OMR_SPECIAL_PERIPH) begin
            mode_d = wmode;
            // special targets stay writable; normal single-chip keeps one write; lsb=1 targets lock
            mode_once_d = 1'b1;
          end
        end else if ((wmode == omr_pkg::OMR_NORMAL_NARROW) || (wmode == omr_pkg::OMR_NORMAL_WIDE)) begin
          mode_d = wmode;
          mode_once_d = 1'b0;
        end else if (wmode == omr_pkg::OMR_NORMAL_SINGLE) begin
          mode_once_d = 1'b0; // same-value write uses up the single write
        end
      end
      if (is_special || (is_normal && internal_visibility_once_q)) begin
        internal_visibility_d = i_wdata[omr_pkg::INTERNAL_VISIBILITY_BIT];
        internal_visibility_once_d = is_special;
      end
      if (is_special || (is_normal && emk_once_q)) begin
        emk_d = i_wdata[omr_pkg::EMK_BIT];
        emk_once_d = is_special;
      end
      if (is_special) begin
        eme_d = i_wdata[omr_pkg::EME_BIT];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= 3'h0;
      internal_visibility_q <= 1'b0;
      emk_q <= 1'b0;
      eme_q <= 1'b0;
      mode_once_q <= 1'b0;
      internal_visibility_once_q <= 1'b0;
      emk_once_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      internal_visibility_q <= internal_visibility_d;
      emk_q <= emk_d;
      eme_q <= eme_d;
      mode_once_q <= mode_once_d;
      internal_visibility_once_q <= internal_visibility_once_d;
      emk_once_q <= emk_once_d;
    end
  end

  // bus answer and map decode
  always_comb begin
    rdata_d = omr_pkg::READ_UNMAPPED;
    rvalid_d = 1'b0;
    echo_d = (i_rd || i_wr) && hit && !mapped;
    if (i_rd && hit && mapped) begin
      rdata_d = {mode_q, 1'b0, internal_visibility_q, 1'b0, emk_q, eme_q} & omr_pkg::IMPL_MASK;
      rvalid_d = 1'b1;
    end
    vis_cyc_d = internal_visibility_q && i_int_access && !in_reset_q;
    pk_map_d = is_single || (!is_periph && !(is_expanded && emk_q));
    pe_map_d = is_single || !((is_expanded || is_periph) && eme_q);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      echo_q <= 1'b0;
      vis_cyc_q <= 1'b0;
      pk_map_q <= 1'b1;
      pe_map_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      echo_q <= echo_d;
      vis_cyc_q <= vis_cyc_d;
      pk_map_q <= pk_map_d;
      pe_map_q <= pe_map_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_ext_echo = echo_q;
  assign o_mode_select_field = mode_q;
  assign o_internal_visibility = internal_visibility_q;
  assign o_int_visible_cycle = vis_cyc_q;
  assign o_port_k_mapped = pk_map_q;
  assign o_port_e_mapped = pe_map_q;
endmodule : omr_operating_mode
`default_nettype wire

//--- omr_pkg.sv
// package: constants for the operating mode control register
package omr_pkg;
  localparam logic [7:0] MODE_REG_ADDR = 8'h0b;
  localparam int MODE_LSB = 5;
  localparam int INTERNAL_VISIBILITY_BIT = 3;
  localparam int EMK_BIT = 1;
  localparam int EME_BIT = 0;
  localparam logic [7:0] IMPL_MASK = 8'heb;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [2:0] {
    OMR_SPECIAL_SINGLE = 3'h0,
    OMR_EMUL_NARROW = 3'h1,
    OMR_SPECIAL_TEST = 3'h2,
    OMR_EMUL_WIDE = 3'h3,
    OMR_NORMAL_SINGLE = 3'h4,
    OMR_NORMAL_NARROW = 3'h5,
    OMR_SPECIAL_PERIPH = 3'h6,
    OMR_NORMAL_WIDE = 3'h7
  } omr_mode_t;

  localparam logic [2:0] RST_FLAGS_EMUL = 3'h7;
  localparam logic [2:0] RST_FLAGS_TEST = 3'h4;
  localparam logic [2:0] RST_FLAGS_OTHER = 3'h0;
endpackage : omr_pkg

//--- tb_top.sv
// testbench: directed register tests of the operating mode register
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_mode_strap = 3'h0;
  logic i_secure = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_int_access = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [2:0] o_mode_select_field;
  logic o_rvalid, o_ext_echo, o_internal_visibility, o_int_visible_cycle, o_port_k_mapped, o_port_e_mapped;
  logic [2:0] m;
  int fails = 0;
  int cmp_count = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  omr_operating_mode i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mode_strap(i_mode_strap),
    .i_secure(i_secure), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_int_access(i_int_access), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_ext_echo(o_ext_echo),
    .o_mode_select_field(o_mode_select_field), .o_internal_visibility(o_internal_visibility),
    .o_int_visible_cycle(o_int_visible_cycle), .o_port_k_mapped(o_port_k_mapped),
    .o_port_e_mapped(o_port_e_mapped));
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rst(input logic [2:0] s);
    i_mode_strap <= s;
    i_rst <= 1'b1;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask : rst
  task wr(input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= 8'h0b;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  // vx holds the expected rvalid and echo pulses
  task rd(input logic [7:0] a, input logic [1:0] vx, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk("rvalid echo", {6'h0, vx}, {6'h0, o_rvalid, o_ext_echo});
    chk("rdata", e, o_rdata);
  endtask : rd
  initial begin
    #400000;
    fails++;
    results;
  end
  initial begin
    for (int s = 0; s < 8; s++) begin
      m = s[2:0];
      rst(m);
      chk("mode", {5'h0, m}, {5'h0, o_mode_select_field});
      chk("maps", {6'h0, m != 3'h6 && m != 3'h1 && m != 3'h3, m != 3'h1 && m != 3'h3},
        {6'h0, o_port_k_mapped, o_port_e_mapped});
      if (m[0] || m == 3'h6) rd(8'h0b, 2'b01, 8'h00);
      else rd(8'h0b, 2'b10, {m, 1'b0, m == 3'h2, 3'h0});
      $display("reset test %0d done", s);
    end
    rst(3'h0);
    wr(8'hdb);
    rd(8'h0b, 2'b10, 8'h0b);
    @(posedge i_ref_clk);
    i_int_access <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk("visible cycle", 8'h01, {7'h0, o_int_visible_cycle});
    wr(8'h80);
    rd(8'h0b, 2'b10, 8'h80);
    wr(8'ha8);
    chk("mode", 8'h05, {5'h0, o_mode_select_field});
    wr(8'h00);
    chk("mode", 8'h05, {5'h0, o_mode_select_field});
    rd(8'h0b, 2'b01, 8'h00);
    $display("special single test done");
    rst(3'h0);
    @(posedge i_ref_clk);
    i_secure <= 1'b1;
    wr(8'h40);
    chk("mode", 8'h00, {5'h0, o_mode_select_field});
    @(posedge i_ref_clk);
    i_secure <= 1'b0;
    wr(8'h40);
    wr(8'he0);
    chk("mode", 8'h07, {5'h0, o_mode_select_field});
    $display("secure test done");
    rst(3'h4);
    wr(8'h0b);
    rd(8'h0b, 2'b10, 8'h8a);
    wr(8'h00);
    rd(8'h0b, 2'b10, 8'h8a);
    rd(8'h0c, 2'b00, 8'h00);
    $display("normal single test done");
    results;
  end
endmodule : tb_top
`default_nettype wire
